/* File: pchfp_port.sv */
// Host parallel port and PCM frame timing of the conference device
`timescale 1ns/10ps
module pchfp_port import pchfp_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic master_reset_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cmd_data_sel_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic pcm_clk_i,
  input wire logic frame_sync_i,
  input wire logic pcm_in_i,
  output logic pcm_out_o,
  output logic pcm_out_oe_o,
  output logic matrix_clock_out_o,
  input wire logic companding_law_select_i,
  output logic law_alaw_o,
  input wire logic legacy_mode_req_i,
  output logic legacy_mode_o,
  output logic extra_bit_o,
  output logic init_busy_o,
  input wire logic [9:0] overflow_i,
  input wire logic [5:0] status_i,
  input wire logic read_match_i,
  input wire logic [7:0] read_data_i,
  output logic cmd_valid_o,
  output logic cmd_is_opcode_o,
  output logic [7:0] cmd_byte_o,
  input wire logic [7:0] tx_word_i,
  output logic tx_load_o,
  output logic [7:0] rx_word_o,
  output logic rx_valid_o
);

  // ****************************************************
  // Pin synchronisation
  // ****************************************************
  logic [16:0] pins_s;
  logic cs_n_s, rd_n_s, wr_n_s, cd_s, pclk_s, fsync_s, pin_s;
  logic mrst_n_s, law_s;
  logic [7:0] data_s;

  pchfp_sync #(.WIDTH(17)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({cs_n_i, rd_n_i, wr_n_i, cmd_data_sel_i, data_i,
              pcm_clk_i, frame_sync_i, pcm_in_i, master_reset_n_i,
              companding_law_select_i}),
    .sync_o(pins_s)
  );

  assign {cs_n_s, rd_n_s, wr_n_s, cd_s, data_s,
          pclk_s, fsync_s, pin_s, mrst_n_s, law_s} = pins_s;

  // Pin reset and system reset both hold the port and frame logic; edge and law registers see system reset only
  logic dev_rst;
  assign dev_rst = reset_i | ~mrst_n_s;

  // ****************************************************
  // Edge detection
  // ****************************************************
  logic rd_n_q, wr_n_q, pclk_q, fsync_q;
  logic wr_rise, rd_fall, pclk_rise, sel;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      pclk_q <= 1'b0;
      fsync_q <= 1'b0;
    end else begin
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
      pclk_q <= pclk_s;
      fsync_q <= pclk_rise ? fsync_s : fsync_q;
    end
  end

  assign wr_rise = wr_n_s & ~wr_n_q;
  assign rd_fall = ~rd_n_s & rd_n_q;
  assign pclk_rise = pclk_s & ~pclk_q;
  assign sel = ~cs_n_s;

  // Marker sampled on master clock rises only
  logic sync_edge;
  assign sync_edge = pclk_rise & fsync_s & ~fsync_q;

  // ****************************************************
  // Law strap and frame length
  // ****************************************************
  logic law_q, law_d;
  logic [FCNT_W-1:0] edge_cnt_q, edge_cnt_d;
  logic [FCNT_W-1:0] frame_len_q, frame_len_d;
  logic [1:0] init_cnt_q, init_cnt_d;
  logic [1:0] supp_q, supp_d;
  logic extra_q, extra_d, ext_pend_q, ext_pend_d;
  logic mclk_q, mclk_d;
  logic busy, legacy_eff;

  assign busy = init_cnt_q != INIT_FRAMES;
  // Legacy limited to frames of 256 bits or fewer
  assign legacy_eff = legacy_mode_req_i &
                      (frame_len_q <= LEGACY_MAX_BITS);

  // ****************************************************
  // Host port
  // ****************************************************
  pchfp_rd_state_type rd_st_q, rd_st_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic cmd_v_q, cmd_v_d, cmd_op_q, cmd_op_d;
  logic [7:0] cmd_b_q, cmd_b_d;

  function automatic logic [7:0] legacy_byte(
    input logic cd,
    input logic [9:0] ovf,
    input logic [5:0] st
  );
    legacy_byte = cd ? {st, ovf[9:8]} : ovf[7:0];
  endfunction

  always_comb begin
    rd_st_d = rd_st_q;
    rd_data_d = rd_data_q;
    cmd_v_d = 1'b0;
    cmd_op_d = cmd_op_q;
    cmd_b_d = cmd_b_q;
    // Deselected strobes latch nothing
    if (wr_rise && sel && !busy) begin
      cmd_v_d = 1'b1;
      cmd_op_d = cd_s;
      cmd_b_d = data_s;
    end
    unique case (rd_st_q)
      PCHFP_RD_IDLE: begin
        if (rd_fall && sel && !busy) begin
          if (legacy_eff) begin
            rd_st_d = PCHFP_RD_DRIVE;
            rd_data_d = legacy_byte(cd_s, overflow_i, status_i);
          end else if (read_match_i) begin
            rd_st_d = PCHFP_RD_DRIVE;
            rd_data_d = read_data_i;
          end
        end
      end
      PCHFP_RD_DRIVE: begin
        if (rd_n_s || cs_n_s) begin
          rd_st_d = PCHFP_RD_IDLE;
        end
      end
      default: rd_st_d = PCHFP_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      rd_st_q <= PCHFP_RD_IDLE;
      rd_data_q <= BYTE_RST;
      cmd_v_q <= 1'b0;
      cmd_op_q <= 1'b0;
      cmd_b_q <= BYTE_RST;
    end else begin
      rd_st_q <= rd_st_d;
      rd_data_q <= rd_data_d;
      cmd_v_q <= cmd_v_d;
      cmd_op_q <= cmd_op_d;
      cmd_b_q <= cmd_b_d;
    end
  end

  // Float whenever deselected, in reset or initialising
  assign data_oe_o = (rd_st_q == PCHFP_RD_DRIVE) & sel & ~dev_rst
                     & ~busy;
  assign data_o = rd_data_q;
  assign cmd_valid_o = cmd_v_q;
  assign cmd_is_opcode_o = cmd_op_q;
  assign cmd_byte_o = cmd_b_q;

  // ****************************************************
  // Frame timing
  // ****************************************************
  logic [FCNT_W-1:0] rx_off, tx_pos, rx_pos;
  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic tx_bit_q, tx_bit_d, tx_ld_q, tx_ld_d, rx_v_q, rx_v_d;

  assign rx_off = extra_q ? RX_OFFSET_EXTRA : RX_OFFSET_NORMAL;
  assign rx_pos = edge_cnt_q - rx_off;
  // Bit 0 leaves one edge ahead of the marker unless extra bit is on
  always_comb begin
    if (extra_q) begin
      tx_pos = edge_cnt_d;
    end else if (edge_cnt_d == frame_len_q - 10'h001) begin
      tx_pos = '0;
    end else begin
      tx_pos = edge_cnt_d + 10'h001;
    end
  end

  always_comb begin
    law_d = law_q;
    edge_cnt_d = edge_cnt_q;
    frame_len_d = frame_len_q;
    init_cnt_d = init_cnt_q;
    supp_d = supp_q;
    extra_d = extra_q;
    ext_pend_d = ext_pend_q;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    tx_ld_d = 1'b0;
    rx_sh_d = rx_sh_q;
    rx_v_d = 1'b0;
    if (!mrst_n_s) begin
      law_d = law_s;
    end
    if (cmd_v_q && cmd_op_q) begin
      ext_pend_d = cmd_b_q == OPC_EXTRA_BIT;
    end else if (cmd_v_q && ext_pend_q) begin
      extra_d = cmd_b_q[0];
      ext_pend_d = 1'b0;
    end
    if (pclk_rise) begin
      if (sync_edge) begin
        edge_cnt_d = '0;
        frame_len_d = edge_cnt_q + 10'h001;
        if (busy) begin
          init_cnt_d = init_cnt_q + 2'h1;
        end
        if (extra_q) begin
          supp_d = SUPPRESS_PERIODS;
        end
      end else begin
        edge_cnt_d = edge_cnt_q + 10'h001;
        if (supp_q != 2'h0) begin
          supp_d = supp_q - 2'h1;
        end
      end
      if (tx_pos[2:0] == 3'h0) begin
        tx_sh_d = tx_word_i;
        tx_ld_d = 1'b1;
        tx_bit_d = tx_word_i[7];
      end else begin
        tx_bit_d = tx_sh_q[3'h7 - tx_pos[2:0]];
      end
      if (!sync_edge && edge_cnt_q + 10'h001 >= rx_off) begin
        rx_sh_d = {rx_sh_q[6:0], pin_s};
        rx_v_d = rx_pos[2:0] == 3'h6;
      end
    end
  end

  // Extra bit: two master periods after the marker are blanked
  // Gate only while enabled, so a late disable never eats a period
  assign mclk_d = pclk_s & ~(extra_q & (supp_d != 2'h0));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      law_q <= 1'b0;
    end else begin
      law_q <= law_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      edge_cnt_q <= '0;
      frame_len_q <= FRAME_LEN_RST;
      init_cnt_q <= '0;
      supp_q <= '0;
      extra_q <= 1'b0;
      ext_pend_q <= 1'b0;
      mclk_q <= 1'b0;
      tx_sh_q <= BYTE_RST;
      tx_bit_q <= 1'b1;
      tx_ld_q <= 1'b0;
      rx_sh_q <= BYTE_RST;
      rx_v_q <= 1'b0;
    end else begin
      edge_cnt_q <= edge_cnt_d;
      frame_len_q <= frame_len_d;
      init_cnt_q <= init_cnt_d;
      supp_q <= supp_d;
      extra_q <= extra_d;
      ext_pend_q <= ext_pend_d;
      mclk_q <= mclk_d;
      tx_sh_q <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_ld_q <= tx_ld_d;
      rx_sh_q <= rx_sh_d;
      rx_v_q <= rx_v_d;
    end
  end

  // Open drain: only ever pulls low
  assign pcm_out_o = 1'b0;
  assign pcm_out_oe_o = ~tx_bit_q & ~busy & ~dev_rst;
  assign matrix_clock_out_o = mclk_q;
  assign law_alaw_o = law_q;
  assign legacy_mode_o = legacy_eff;
  assign extra_bit_o = extra_q;
  assign init_busy_o = busy;
  assign tx_load_o = tx_ld_q;
  assign rx_word_o = rx_sh_q;
  assign rx_valid_o = rx_v_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  sequence s_sel_write;
    wr_rise && sel && !busy && !dev_rst;
  endsequence

  sequence s_latched;
    cmd_valid_o && cmd_byte_o == $past(data_s)
      && cmd_is_opcode_o == $past(cd_s);
  endsequence

  AST_WR_CAPTURE: assert property (@(posedge clk_i) disable iff (reset_i)
    s_sel_write |=> s_latched)
    else $error("write byte not captured");

  AST_NO_CS_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_rise && !sel |=> !cmd_valid_o)
    else $error("deselected write latched");

  AST_CS_TRI: assert property (@(posedge clk_i) disable iff (reset_i)
    cs_n_s |-> !data_oe_o)
    else $error("bus driven while deselected");

  AST_RST_TRI: assert property (@(posedge clk_i) disable iff (reset_i)
    !mrst_n_s |-> !data_oe_o && !pcm_out_oe_o)
    else $error("driving during master reset");

  AST_INIT_TRI: assert property (@(posedge clk_i) disable iff (reset_i)
    busy |-> !data_oe_o && !pcm_out_oe_o)
    else $error("driving during initialisation");

  AST_LEGACY_RD: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_fall && sel && !busy && !dev_rst && legacy_eff && !rd_n_s
      ##1 sel && !rd_n_s |-> data_oe_o
      && data_o == legacy_byte($past(cd_s), $past(overflow_i),
                               $past(status_i)))
    else $error("legacy read byte wrong");

  AST_MODE_LIMIT: assert property (@(posedge clk_i) disable iff (reset_i)
    frame_len_q > LEGACY_MAX_BITS |-> !legacy_mode_o)
    else $error("legacy mode above 256 bit frames");

  AST_CLK_FWD: assert property (@(posedge clk_i) disable iff (dev_rst)
    !extra_q && $past(!extra_q) && !$past(dev_rst)
      |-> matrix_clock_out_o == $past(pclk_s))
    else $error("matrix clock not forwarded");

  AST_SUPPRESS: assert property (@(posedge clk_i) disable iff (dev_rst)
    sync_edge && extra_q |=> supp_q == SUPPRESS_PERIODS && !mclk_q)
    else $error("extra bit periods not suppressed");

  AST_RX_FIRST: assert property (@(posedge clk_i) disable iff (dev_rst)
    pclk_rise && !sync_edge && edge_cnt_q + 10'h001 == rx_off
      |=> rx_sh_q[0] == $past(pin_s))
    else $error("first input bit not sampled");

  AST_LAW_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    mrst_n_s && $past(mrst_n_s) |-> $stable(law_alaw_o))
    else $error("law changed outside reset");

endmodule // pchfp_port

/* File: pchfp_pkg.sv */
// Constants for the PCM conference host and frame port
package pchfp_pkg;

  localparam int FCNT_W = 10;
  localparam logic [7:0] OPC_EXTRA_BIT = 8'h05;
  localparam logic [FCNT_W-1:0] LEGACY_MAX_BITS = 10'h100;
  localparam logic [FCNT_W-1:0] RX_OFFSET_NORMAL = 10'h001;
  localparam logic [FCNT_W-1:0] RX_OFFSET_EXTRA = 10'h003;
  localparam logic [1:0] SUPPRESS_PERIODS = 2'h2;
  localparam logic [1:0] INIT_FRAMES = 2'h2;
  localparam logic [FCNT_W-1:0] FRAME_LEN_RST = 10'h100;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    PCHFP_RD_IDLE = 2'b01,
    PCHFP_RD_DRIVE = 2'b10
  } pchfp_rd_state_type;

endpackage

/* File: pchfp_sync.sv */
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/10ps
module pchfp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // pchfp_sync

/* File: pchfp_far_end.sv */
// Far-end model: PCM master clock, frame marker and serial input line
`timescale 1ns/10ps
module pchfp_far_end (
  input wire logic [9:0] frame_len_i,
  input wire logic extra_i,
  output logic pcm_clk_o,
  output logic frame_sync_o,
  output logic pcm_in_o
);
  // **************************************************
  // Frame timing and serial stimulus
  // **************************************************
  localparam logic [15:0] PATTERN = 16'hA73C;
  int n;
  int slot;

  initial begin
    pcm_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    pcm_in_o = 1'b1;
    n = 0;
    // Offset keeps clock edges away from the system clock edges
    #3;
    forever begin
      #50 pcm_clk_o = 1'b1;
      n = (n + 1 >= int'(frame_len_i)) ? 0 : n + 1;
      #50 pcm_clk_o = 1'b0;
      // High for one period, seen at the rise where n wraps
      frame_sync_o = (n == int'(frame_len_i) - 1);
      slot = n + 1 - (extra_i ? 3 : 1);
      // Idle slots are ones, so a slipped word never looks right
      pcm_in_o = (slot >= 0 && slot < 16) ? PATTERN[15 - slot] : 1'b1;
    end
  end
endmodule // pchfp_far_end

/* File: tb.sv */
// Self-checking testbench of the PCM host and frame port
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
  localparam logic [7:0] W0 = 8'hA7;
  localparam logic [7:0] W1 = 8'h3C;
  logic clk_i = 1'b0, reset_i = 1'b1, mrst_n = 1'b0, cs_n = 1'b1;
  logic rd_n = 1'b1, wr_n = 1'b1, cd = 1'b0, law = 1'b0, legacy = 1'b1;
  logic match = 1'b0, extra = 1'b0, mon_en = 1'b0, armed = 1'b0;
  logic got_w0 = 1'b0, prev_w0 = 1'b0, sync_d = 1'b0, mclk_d = 1'b0;
  logic [7:0] din = 8'h00, rdata = 8'h00, txw = 8'h00;
  logic [9:0] ovf = 10'h000, flen = 10'h018;
  logic [5:0] st = 6'h00;
  logic [31:0] seed = 32'h39E78058;
  logic [7:0] data_o, cmd_byte, rx_word;
  logic data_oe, pcm_clk, fsync, pcm_in, pcm_out, pcm_out_oe, mclk_out;
  logic law_o, legacy_o, extra_o, busy, cmd_valid, cmd_op, rx_valid;
  logic tx_load, pclk_d = 1'b0;
  logic [7:0] txbits = 8'h00;
  logic [7:0] txq[$];
  int err_total = 0, cmp_count = 0, rises = 0, nbits = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) txw <= txw + 8'h1D;

  pchfp_far_end pchfp_far_end_i (.frame_len_i(flen), .extra_i(extra),
    .pcm_clk_o(pcm_clk), .frame_sync_o(fsync), .pcm_in_o(pcm_in));

  pchfp_port pchfp_port_i (.clk_i(clk_i), .reset_i(reset_i),
    .master_reset_n_i(mrst_n), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .cmd_data_sel_i(cd), .data_i(din), .data_o(data_o), .data_oe_o(data_oe),
    .pcm_clk_i(pcm_clk), .frame_sync_i(fsync), .pcm_in_i(pcm_in),
    .pcm_out_o(pcm_out), .pcm_out_oe_o(pcm_out_oe),
    .matrix_clock_out_o(mclk_out), .companding_law_select_i(law),
    .law_alaw_o(law_o), .legacy_mode_req_i(legacy),
    .legacy_mode_o(legacy_o), .extra_bit_o(extra_o), .init_busy_o(busy),
    .overflow_i(ovf), .status_i(st), .read_match_i(match),
    .read_data_i(rdata), .cmd_valid_o(cmd_valid), .cmd_is_opcode_o(cmd_op),
    .cmd_byte_o(cmd_byte), .tx_word_i(txw), .tx_load_o(tx_load),
    .rx_word_o(rx_word), .rx_valid_o(rx_valid));

  function automatic logic [31:0] rnd_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // **************************************************
  // Host transfers
  // **************************************************
  task automatic host_wr(input logic sel, input logic c, input logic [7:0] b);
    logic got;
    @(posedge clk_i);
    cs_n <= ~sel;
    cd <= c;
    din <= b;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n <= 1'b1;
    got = 1'b0;
    repeat (8) begin
      @(negedge clk_i);
      if (cmd_valid === 1'b1) begin
        got = 1'b1;
        `CHK("cmd_byte", b, cmd_byte)
        `CHK("cmd_is_opcode", c, cmd_op)
      end
    end
    `CHK("cmd_valid", sel, got)
    @(posedge clk_i);
    cs_n <= 1'b1;
  endtask

  task automatic host_rd(input logic c, input logic eoe, input logic [7:0] ed);
    logic seen;
    logic [7:0] got;
    @(posedge clk_i);
    cs_n <= 1'b0;
    cd <= c;
    rd_n <= 1'b0;
    seen = 1'b0;
    got = 8'h00;
    repeat (8) begin
      @(negedge clk_i);
      if (data_oe === 1'b1 && !seen) begin
        seen = 1'b1;
        got = data_o;
      end
    end
    `CHK("read_oe", eoe, seen)
    if (eoe) `CHK("read_data", ed, got)
    // Chip select leaves first: the bus must float with the strobe low
    @(posedge clk_i);
    cs_n <= 1'b1;
    repeat (5) @(negedge clk_i);
    `CHK("oe_after_cs", 1'b0, data_oe)
    @(posedge clk_i);
    rd_n <= 1'b1;
  endtask

  task automatic dev_reset(input logic l);
    @(posedge clk_i);
    law <= l;
    @(posedge clk_i);
    mrst_n <= 1'b0;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (10) @(negedge clk_i);
    `CHK("oe_in_reset", 1'b0, data_oe)
    @(posedge clk_i);
    mrst_n <= 1'b1;
    repeat (20) @(negedge clk_i);
    `CHK("busy", 1'b1, busy)
    `CHK("oe_in_init", 1'b0, data_oe)
    `CHK("pcm_oe_in_init", 1'b0, pcm_out_oe)
    @(posedge clk_i);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk_i);
    `CHK("busy_end", 1'b0, busy)
    `CHK("law", l, law_o)
  endtask

  // **************************************************
  // Frame monitor
  // **************************************************
  always @(negedge clk_i) begin
    if (mclk_out === 1'b1 && mclk_d === 1'b0) rises++;
    // Output line is settled by the master clock fall
    if (!pcm_clk && pclk_d) begin
      txbits = {txbits[6:0], ~pcm_out_oe};
      nbits++;
    end
    if (tx_load === 1'b1) begin
      if (txq.size() > 0 && armed && mon_en) begin
        `CHK("tx_bits", 8, nbits)
        `CHK("tx_word", txq[0], txbits)
      end
      // Word was taken one edge before txw stepped on
      txq = {8'(txw - 8'h1D)};
      nbits = 0;
    end
    if (rx_valid === 1'b1) begin
      if (armed && mon_en && prev_w0) `CHK("rx_word", W1, rx_word)
      if (rx_word === W0) got_w0 = 1'b1;
      prev_w0 = (rx_word === W0);
    end
    if (fsync && !sync_d) begin
      if (armed && mon_en) begin
        `CHK("mclk_rises", extra ? int'(flen) - 2 : int'(flen), rises)
        `CHK("rx_first_word", 1'b1, got_w0)
        `CHK("pcm_out_level", 1'b0, pcm_out)
        `CHK("tx_align", extra ? 8 : 1, nbits)
      end
      armed = mon_en;
      rises = 0;
      got_w0 = 1'b0;
    end
    sync_d = fsync;
    mclk_d = mclk_out;
    pclk_d = pcm_clk;
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    $display("timeout");
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    dev_reset(1'b1);
    dev_reset(1'b0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      seed = rnd_next(seed);
      host_wr(1'b1, seed[8], seed[7:0] | 8'h80);
    end
    host_wr(1'b0, 1'b1, 8'h5A);
    $display("test writes done");
    for (int i = 0; i < 16; i++) begin
      seed = rnd_next(seed);
      @(posedge clk_i);
      legacy <= (i < 8);
      ovf <= seed[9:0];
      st <= seed[15:10];
      rdata <= seed[23:16];
      match <= seed[24];
      @(posedge clk_i);
      if (legacy) `CHK("legacy_mode", 1'b1, legacy_o)
      if (legacy) host_rd(i[0], 1'b1, i[0] ? {st, ovf[9:8]} : ovf[7:0]);
      else host_rd(i[0], match, rdata);
    end
    $display("test reads done");
    mon_en <= 1'b1;
    repeat (800) @(posedge clk_i);
    mon_en <= 1'b0;
    host_wr(1'b1, 1'b1, pchfp_pkg::OPC_EXTRA_BIT);
    host_wr(1'b1, 1'b0, 8'h01);
    `CHK("extra_on", 1'b1, extra_o)
    extra <= 1'b1;
    repeat (300) @(posedge clk_i);
    mon_en <= 1'b1;
    repeat (800) @(posedge clk_i);
    mon_en <= 1'b0;
    host_wr(1'b1, 1'b1, pchfp_pkg::OPC_EXTRA_BIT);
    host_wr(1'b1, 1'b0, 8'h00);
    `CHK("extra_off", 1'b0, extra_o)
    extra <= 1'b0;
    $display("test frames done");
    legacy <= 1'b1;
    flen <= 10'h104;
    repeat (8000) @(posedge clk_i);
    `CHK("legacy_long_frame", 1'b0, legacy_o)
    $display("test legacy limit done");
    final_report();
  end
endmodule // tb
